// ---- src/tts_regs.svh ----
// offsets, field positions, command codes and timing counts for the
// tear trigger and self-diagnostic block; definitions only
`ifndef TTS_REGS_SVH
`define TTS_REGS_SVH

// register offsets on the plain register port
`define TTS_REG_STAT 4'h0
`define TTS_REG_ENA 4'h1
`define TTS_REG_CLR 4'h2
`define TTS_REG_DIAG 4'h3
`define TTS_REG_STATE 4'h4

// event bit positions in status, enable and clear
`define TTS_EV_TRIG 0
`define TTS_EV_ACKERR 1
`define TTS_EV_DDONE 2
`define TTS_EV_DFAIL 3
`define TTS_EV_W 4

// self-diagnostic result bit positions
`define TTS_DIAG_LOAD 7
`define TTS_DIAG_FUNC 6

// reset values
`define TTS_DIAG_RST 8'h00
`define TTS_EV_RST 4'h0

// command codes
`define TTS_CMD_SLPIN 8'h10
`define TTS_CMD_SLPOUT 8'h11
`define TTS_CMD_TEOFF 8'h34
`define TTS_CMD_TEON 8'h35
`define TTS_CMD_RNG0_LO 8'h00
`define TTS_CMD_RNG0_HI 8'haf
`define TTS_CMD_RNG1_LO 8'hda
`define TTS_CMD_RNG1_HI 8'hdd

// timing
`define TTS_CLK_MHZ 100
`define TTS_T_SLPIN_MS 120
`define TTS_T_SLPOUT_MS 5
`define TTS_HOLD_CYC 4'h8

`endif

// ---- src/tts_pkg.sv ----
// types of the tear trigger and self-diagnostic block
// assumes nothing beyond a SystemVerilog compiler
package tts_pkg;

  // link sequencer states, one-hot
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_LP11 = 8'h02,
    ST_WAIT_VS = 8'h04,
    ST_TRIG = 8'h08,
    ST_LP11B = 8'h10,
    ST_BTA = 8'h20,
    ST_ACKERR = 8'h40,
    ST_LP1 = 8'h80
  } tts_state_t;

  // what the device drives onto the data lane
  typedef enum logic [2:0] {
    LN_LP11 = 3'h0,
    LN_TRIG = 3'h1,
    LN_ACKERR = 3'h2,
    LN_LP1 = 3'h3,
    LN_BTA = 3'h4
  } tts_lane_t;

endpackage

// ---- src/tts_rx_if.sv ----
// decoded packets and turnaround requests from the link receiver
// assumes both ends run on clk_sys_i
`timescale 1ns/1ps
`default_nettype none
interface tts_rx_if;
  logic pkt_valid;
  logic pkt_err;
  logic pkt_has_param;
  logic [7:0] pkt_cmd;
  logic [7:0] pkt_param;
  logic bta_req;
  modport rx (output pkt_valid, pkt_err, pkt_has_param, pkt_cmd,
    pkt_param, bta_req);
  modport core (input pkt_valid, pkt_err, pkt_has_param, pkt_cmd,
    pkt_param, bta_req);
endinterface
`default_nettype wire

// ---- src/tts_rx.sv ----
// link receiver: samples the link clock, frame and data pins
// assumes the link clock is far slower than clk_sys_i
`timescale 1ns/1ps
`default_nettype none
`include "tts_regs.svh"
module tts_rx (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic lnk_clk_i,
  input wire logic lnk_frm_i,
  input wire logic lnk_dat_i,
  input wire logic lnk_bta_i,
  tts_rx_if.rx pkt
);
  import tts_pkg::*;

  // bit 3 bta, 2 link clock, 1 frame, 0 data
  logic [3:0] sy1;
  logic [3:0] sy2;
  logic [3:0] sy3;
  logic [23:0] shf;
  logic [23:0] next_shf;
  logic [5:0] nbit;
  logic [5:0] next_nbit;
  logic valid;
  logic next_valid;
  logic err;
  logic next_err;
  logic has;
  logic next_has;
  logic [7:0] cmd;
  logic [7:0] next_cmd;
  logic [7:0] par;
  logic [7:0] next_par;
  logic bta;
  logic next_bta;
  logic clk_rise;
  logic frm_fall;

  assign clk_rise = sy2[2] & ~sy3[2];
  assign frm_fall = sy3[1] & ~sy2[1];

  // shift on rising link clock edges, decode when the lane returns to stop
  always_comb
  begin
    next_shf = shf;
    next_nbit = nbit;
    next_valid = 1'b0;
    next_err = err;
    next_has = has;
    next_cmd = cmd;
    next_par = par;
    next_bta = sy2[3] & ~sy3[3];
    if (sy2[1] && clk_rise)
    begin
      next_shf = {shf[22:0], sy2[0]};
      if (nbit != 6'h3f)
        next_nbit = nbit + 6'h01;
    end
    if (frm_fall)
    begin
      next_valid = 1'b1;
      next_nbit = 6'h00;
      next_par = 8'h00;
      next_has = 1'b0;
      // short packet with no parameter: command then check
      if (nbit == 6'h10)
      begin
        next_cmd = shf[15:8];
        next_err = (shf[7:0] != shf[15:8]);
      end
      // one parameter: command, parameter, check
      else if (nbit == 6'h18)
      begin
        next_cmd = shf[23:16];
        next_par = shf[15:8];
        next_has = 1'b1;
        next_err = (shf[7:0] != (shf[23:16] ^ shf[15:8]));
      end
      else
      begin
        next_cmd = shf[23:16];
        next_err = 1'b1;
      end
    end
  end

  // pins pass two flops before anything reads them
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sy1 <= 4'h0;
      sy2 <= 4'h0;
      sy3 <= 4'h0;
      shf <= 24'h000000;
      nbit <= 6'h00;
      valid <= 1'b0;
      err <= 1'b0;
      has <= 1'b0;
      cmd <= 8'h00;
      par <= 8'h00;
      bta <= 1'b0;
    end
    else
    begin
      sy1 <= {lnk_bta_i, lnk_clk_i, lnk_frm_i, lnk_dat_i};
      sy2 <= sy1;
      sy3 <= sy2;
      shf <= next_shf;
      nbit <= next_nbit;
      valid <= next_valid;
      err <= next_err;
      has <= next_has;
      cmd <= next_cmd;
      par <= next_par;
      bta <= next_bta;
    end
  end

  assign pkt.pkt_valid = valid;
  assign pkt.pkt_err = err;
  assign pkt.pkt_has_param = has;
  assign pkt.pkt_cmd = cmd;
  assign pkt.pkt_param = par;
  assign pkt.bta_req = bta;
endmodule
`default_nettype wire

// ---- src/tts_top.sv ----
// tear trigger sequencer, tear-sync line and sleep-exit self-diagnostics
// assumes vsync_i, hsync_i, nv_match_i, func_ok_i come from clk_sys_i logic
`timescale 1ns/1ps
`default_nettype none
`include "tts_regs.svh"
module tts_top #(
  parameter logic [23:0] DIAG_LONG_CYC =
    24'(`TTS_T_SLPIN_MS * 1000 * `TTS_CLK_MHZ),
  parameter logic [23:0] DIAG_SHORT_CYC =
    24'(`TTS_T_SLPOUT_MS * 1000 * `TTS_CLK_MHZ)
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic lnk_clk_i,
  input wire logic lnk_frm_i,
  input wire logic lnk_dat_i,
  input wire logic lnk_bta_i,
  output tts_pkg::tts_lane_t lane_state_o,
  output logic lane_oe_o,
  input wire logic vsync_i,
  input wire logic hsync_i,
  input wire logic nv_match_i,
  input wire logic func_ok_i,
  output logic tear_sync_line_o,
  output logic cfg_wr_o,
  output logic [7:0] cfg_cmd_o,
  output logic [7:0] cfg_param_o,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic irq_o
);
  import tts_pkg::*;

  tts_rx_if rxi ();

  tts_rx u_rx (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .lnk_clk_i(lnk_clk_i),
    .lnk_frm_i(lnk_frm_i),
    .lnk_dat_i(lnk_dat_i),
    .lnk_bta_i(lnk_bta_i),
    .pkt(rxi.rx)
  );

  tts_state_t st;
  tts_state_t next_st;
  logic [3:0] hold_cnt;
  logic [3:0] next_hold_cnt;
  tts_lane_t next_lane;
  logic next_lane_oe;
  logic hold_done;
  logic vs_q;
  logic vs_rise;
  logic sleep_in, next_sleep_in;
  logic tear_on, next_tear_on;
  logic mode2, next_mode2;
  logic trig_en, next_trig_en;
  logic force_low, next_force_low;
  logic loaded, next_loaded;
  logic err_flag, next_err_flag;
  logic armed, next_armed;
  logic [7:0] diag, next_diag;
  logic [23:0] diag_cnt, next_diag_cnt;
  logic diag_run, next_diag_run;
  logic next_tsl;
  logic next_cfg_wr;
  logic [7:0] next_cfg_cmd;
  logic [7:0] next_cfg_param;
  logic slpout_cmd;
  logic diag_fire;
  logic trig_sent;
  logic [`TTS_EV_W-1:0] stat, next_stat;
  logic [`TTS_EV_W-1:0] ena, next_ena;
  logic [`TTS_EV_W-1:0] ev;
  logic [7:0] next_rdata;
  logic next_irq;

  assign hold_done = (hold_cnt == (`TTS_HOLD_CYC - 4'h1));
  assign vs_rise = vsync_i & ~vs_q;
  assign slpout_cmd = rxi.pkt_valid & ~rxi.pkt_err &
    (rxi.pkt_cmd == `TTS_CMD_SLPOUT);
  assign diag_fire = diag_run & (diag_cnt == 24'h000000);
  assign trig_sent = (st == ST_TRIG) & hold_done;

  // link sequencer: every drive phase except the wait for vsync lasts a fixed hold time
  always_comb
  begin
    next_st = st;
    next_hold_cnt = hold_done ? 4'h0 : hold_cnt + 4'h1;
    case (st)
      ST_IDLE:
      begin
        next_hold_cnt = 4'h0;
        if (rxi.bta_req)
          next_st = ST_LP11;
      end
      ST_LP11:
        if (hold_done)
        begin
          if (err_flag)
            next_st = ST_ACKERR;
          else if (armed)
            next_st = ST_WAIT_VS;
          else
            next_st = ST_BTA;
        end
      ST_WAIT_VS:
      begin
        next_hold_cnt = 4'h0;
        if (vs_rise)
          next_st = ST_TRIG;
      end
      ST_TRIG:
        if (hold_done)
          next_st = ST_LP11B;
      ST_LP11B:
        if (hold_done)
          next_st = ST_BTA;
      ST_ACKERR:
        if (hold_done)
          next_st = ST_LP1;
      ST_LP1:
        if (hold_done)
          next_st = ST_BTA;
      ST_BTA:
        if (hold_done)
          next_st = ST_IDLE;
      default:
        next_st = ST_IDLE;
    endcase
    // lane drive follows the state being entered
    next_lane_oe = (next_st != ST_IDLE);
    case (next_st)
      ST_TRIG: next_lane = LN_TRIG;
      ST_ACKERR: next_lane = LN_ACKERR;
      ST_LP1: next_lane = LN_LP1;
      ST_BTA: next_lane = LN_BTA;
      default: next_lane = LN_LP11;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st <= ST_IDLE;
      hold_cnt <= 4'h0;
      lane_state_o <= LN_LP11;
      lane_oe_o <= 1'b0;
      vs_q <= 1'b0;
    end
    else
    begin
      st <= next_st;
      hold_cnt <= next_hold_cnt;
      lane_state_o <= next_lane;
      lane_oe_o <= next_lane_oe;
      vs_q <= vsync_i;
    end
  end

  // command decode, tear line and self-diagnostics
  always_comb
  begin
    next_sleep_in = sleep_in;
    next_tear_on = tear_on;
    next_mode2 = mode2;
    next_trig_en = trig_en;
    next_force_low = force_low;
    next_loaded = loaded;
    next_err_flag = err_flag;
    next_armed = armed;
    next_diag = diag;
    next_diag_cnt = diag_run ? diag_cnt - 24'h000001 : diag_cnt;
    next_diag_run = diag_run & ~diag_fire;
    next_cfg_wr = 1'b0;
    next_cfg_cmd = cfg_cmd_o;
    next_cfg_param = cfg_param_o;
    // the trigger is spent once sent; a new mode 1 enable with a parameter re-arms it
    if (trig_sent)
      next_armed = 1'b0;
    if (st == ST_BTA && hold_done)
      next_err_flag = 1'b0;
    if (rxi.pkt_valid)
    begin
      next_err_flag = rxi.pkt_err;
      if (!rxi.pkt_err)
      begin
        case (rxi.pkt_cmd)
          `TTS_CMD_TEON:
          begin
            next_tear_on = 1'b1;
            next_force_low = 1'b0;
            next_mode2 = rxi.pkt_param[0];
            next_trig_en = ~rxi.pkt_param[0];
            next_armed = rxi.pkt_has_param & ~rxi.pkt_param[0];
          end
          `TTS_CMD_TEOFF:
          begin
            next_tear_on = 1'b0;
            next_trig_en = 1'b0;
            next_armed = 1'b0;
          end
          `TTS_CMD_SLPIN:
            next_sleep_in = 1'b1;
          `TTS_CMD_SLPOUT:
          begin
            // compare first, then load: the load itself is external
            next_loaded = 1'b1;
            if (nv_match_i)
              next_diag[`TTS_DIAG_LOAD] = ~diag[`TTS_DIAG_LOAD];
            else
              next_force_low = 1'b1;
            next_diag_cnt = sleep_in ? DIAG_LONG_CYC : DIAG_SHORT_CYC;
            next_diag_run = 1'b1;
            next_sleep_in = 1'b0;
          end
          default:
          begin
            // register writes only until the first compare-and-load
            if (!loaded &&
                (rxi.pkt_cmd <= `TTS_CMD_RNG0_HI ||
                 (rxi.pkt_cmd >= `TTS_CMD_RNG1_LO &&
                  rxi.pkt_cmd <= `TTS_CMD_RNG1_HI)))
            begin
              next_cfg_wr = 1'b1;
              next_cfg_cmd = rxi.pkt_cmd;
              next_cfg_param = rxi.pkt_param;
            end
          end
        endcase
      end
    end
    if (diag_fire)
    begin
      if (func_ok_i)
        next_diag[`TTS_DIAG_FUNC] = ~diag[`TTS_DIAG_FUNC];
      else
        next_force_low = 1'b1;
    end
    // mode 2 adds horizontal pulses; sleep always wins
    next_tsl = ~sleep_in & tear_on & ~force_low &
      (vsync_i | (mode2 & hsync_i));
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sleep_in <= 1'b1;
      tear_on <= 1'b0;
      mode2 <= 1'b0;
      trig_en <= 1'b0;
      force_low <= 1'b0;
      loaded <= 1'b0;
      err_flag <= 1'b0;
      armed <= 1'b0;
      diag <= `TTS_DIAG_RST;
      diag_cnt <= 24'h000000;
      diag_run <= 1'b0;
      tear_sync_line_o <= 1'b0;
      cfg_wr_o <= 1'b0;
      cfg_cmd_o <= 8'h00;
      cfg_param_o <= 8'h00;
    end
    else
    begin
      sleep_in <= next_sleep_in;
      tear_on <= next_tear_on;
      mode2 <= next_mode2;
      trig_en <= next_trig_en;
      force_low <= next_force_low;
      loaded <= next_loaded;
      err_flag <= next_err_flag;
      armed <= next_armed;
      diag <= next_diag;
      diag_cnt <= next_diag_cnt;
      diag_run <= next_diag_run;
      tear_sync_line_o <= next_tsl;
      cfg_wr_o <= next_cfg_wr;
      cfg_cmd_o <= next_cfg_cmd;
      cfg_param_o <= next_cfg_param;
    end
  end

  // events, sticky status, register port; a set beats a clear
  assign ev[`TTS_EV_TRIG] = trig_sent;
  assign ev[`TTS_EV_ACKERR] = (st == ST_ACKERR) & hold_done;
  assign ev[`TTS_EV_DDONE] = diag_fire;
  assign ev[`TTS_EV_DFAIL] = (diag_fire & ~func_ok_i) |
    (slpout_cmd & ~nv_match_i);

  always_comb
  begin
    next_stat = stat;
    next_ena = ena;
    next_rdata = 8'h00;
    if (reg_wr_i && reg_addr_i == `TTS_REG_CLR)
      next_stat = stat & ~reg_wdata_i[`TTS_EV_W-1:0];
    if (reg_wr_i && reg_addr_i == `TTS_REG_ENA)
      next_ena = reg_wdata_i[`TTS_EV_W-1:0];
    next_stat = next_stat | ev;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        `TTS_REG_STAT: next_rdata = {4'h0, stat};
        `TTS_REG_ENA: next_rdata = {4'h0, ena};
        `TTS_REG_DIAG: next_rdata = diag;
        `TTS_REG_STATE: next_rdata = {2'h0, armed, loaded, force_low,
          trig_en, tear_on, sleep_in};
        default: next_rdata = 8'h00;
      endcase
    end
    next_irq = |(next_stat & next_ena);
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      stat <= `TTS_EV_RST;
      ena <= `TTS_EV_RST;
      reg_rdata_o <= 8'h00;
      irq_o <= 1'b0;
    end
    else
    begin
      stat <= next_stat;
      ena <= next_ena;
      reg_rdata_o <= next_rdata;
      irq_o <= next_irq;
    end
  end

  // checks on the sequencer and the diagnostics
  sequence s_trig_tail;
    (st == ST_LP11B) ##[1:10] (st == ST_BTA);
  endsequence
  sequence s_err_tail;
    (st == ST_ACKERR) ##[1:10] (st == ST_LP1) ##[1:10] (st == ST_BTA);
  endsequence

  property p_take_bus;
    @(posedge clk_sys_i) disable iff (rst_i)
    (st == ST_IDLE && rxi.bta_req) |=> (st == ST_LP11) ##1 lane_oe_o;
  endproperty
  a_take_bus: assert property (p_take_bus) else $error("bus not taken");

  property p_trig_on_vs;
    @(posedge clk_sys_i) disable iff (rst_i)
    $rose(st == ST_TRIG) |-> $past(vs_rise) && $past(armed);
  endproperty
  a_trig_on_vs: assert property (p_trig_on_vs) else $error("off vsync");

  property p_trig_return;
    @(posedge clk_sys_i) disable iff (rst_i)
    (st == ST_TRIG && hold_done) |=> s_trig_tail;
  endproperty
  a_trig_return: assert property (p_trig_return) else $error("no bta");

  property p_err_report;
    @(posedge clk_sys_i) disable iff (rst_i)
    (st == ST_LP11 && hold_done && err_flag) |=> s_err_tail;
  endproperty
  a_err_report: assert property (p_err_report) else $error("no report");

  property p_load_toggle;
    @(posedge clk_sys_i) disable iff (rst_i)
    slpout_cmd |=> (diag[7] != $past(diag[7])) == $past(nv_match_i);
  endproperty
  a_load_toggle: assert property (p_load_toggle) else $error("bit 7");

  property p_mismatch_low;
    @(posedge clk_sys_i) disable iff (rst_i)
    (slpout_cmd && !nv_match_i) |=> force_low ##1 !tear_sync_line_o;
  endproperty
  a_mismatch_low: assert property (p_mismatch_low) else $error("no low");

  property p_func_toggle;
    @(posedge clk_sys_i) disable iff (rst_i)
    diag_fire |=> (diag[6] != $past(diag[6])) == $past(func_ok_i);
  endproperty
  a_func_toggle: assert property (p_func_toggle) else $error("bit 6");

  property p_sleep_low;
    @(posedge clk_sys_i) disable iff (rst_i)
    sleep_in |=> !tear_sync_line_o;
  endproperty
  a_sleep_low: assert property (p_sleep_low) else $error("high asleep");

  property p_cfg_gate;
    @(posedge clk_sys_i) disable iff (rst_i)
    cfg_wr_o |-> $past(!loaded);
  endproperty
  a_cfg_gate: assert property (p_cfg_gate) else $error("late write");
endmodule
`default_nettype wire

// ---- tb/tts_host.sv ----
// host side of the serial link: short writes and turnaround requests
// assumes the device samples these pins with its own clock
`timescale 1ns/1ps
`default_nettype none
module tts_host (
  output logic lnk_clk_o,
  output logic lnk_frm_o,
  output logic lnk_dat_o,
  output logic lnk_bta_o
);
  // stop state, clock parked low between frames
  initial
  begin
    lnk_clk_o = 1'b0;
    lnk_frm_o = 1'b0;
    lnk_dat_o = 1'b0;
    lnk_bta_o = 1'b0;
  end

  // one packet, msb first; n is 16 or 24 bits
  task automatic send(input logic [23:0] b, input int n);
    #3 lnk_frm_o = 1'b1;
    #40;
    for (int i = n - 1; i >= 0; i--)
    begin
      lnk_dat_o = b[i];
      #40 lnk_clk_o = 1'b1;
      #40 lnk_clk_o = 1'b0;
    end
    lnk_frm_o = 1'b0;
    lnk_dat_o = ~lnk_dat_o; // released line must not look like data
    #80;
  endtask

  // hand the lane over; only the lane is used, never the tear line
  task automatic turn();
    #3 lnk_bta_o = 1'b1;
    #300 lnk_bta_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- tb/tts_top_tb.sv ----
// self-checking bench for the tear trigger and self-diagnostic block
// assumes tts_host drives the link; timing and results come from here
`timescale 1ns/1ps
`default_nettype none
`include "tts_regs.svh"
module tts_top_tb;
  import tts_pkg::*;
  logic clk_sys_i, rst_i, vsync_i, hsync_i, nv_match_i, func_ok_i;
  logic lnk_clk, lnk_frm, lnk_dat, lnk_bta;
  logic reg_wr_i, reg_rd_i, lane_oe_o, tear_sync_line_o, cfg_wr_o, irq_o;
  logic [3:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, cfg_cmd_o, cfg_param_o;
  tts_lane_t lane_state_o;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  int wr_cnt = 0;
  int seed = 32'he527;
  // trigger cases: clean mode 1, mode 2, bad check byte, disabled
  logic [23:0] tp [4] = '{24'h350035, 24'h350134, 24'h350036, 24'h003434};
  logic [15:0] exp_seq [4] = '{16'h1215, 16'h0015, 16'h1345, 16'h0015};

  tts_host u_host (.lnk_clk_o(lnk_clk), .lnk_frm_o(lnk_frm),
    .lnk_dat_o(lnk_dat), .lnk_bta_o(lnk_bta));

  // short diag timers keep the run brief
  tts_top #(.DIAG_LONG_CYC(24'hc8), .DIAG_SHORT_CYC(24'h32)) u_dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .lnk_clk_i(lnk_clk),
    .lnk_frm_i(lnk_frm), .lnk_dat_i(lnk_dat), .lnk_bta_i(lnk_bta),
    .lane_state_o(lane_state_o), .lane_oe_o(lane_oe_o),
    .vsync_i(vsync_i), .hsync_i(hsync_i), .nv_match_i(nv_match_i),
    .func_ok_i(func_ok_i), .tear_sync_line_o(tear_sync_line_o),
    .cfg_wr_o(cfg_wr_o), .cfg_cmd_o(cfg_cmd_o), .cfg_param_o(cfg_param_o),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .irq_o(irq_o));

  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // vsync every 300 cycles, random hsync, pulse count, hang guard
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    vsync_i <= (cyc % 300) < 5;
    hsync_i <= 1'($random(seed));
    if (cfg_wr_o === 1'b1)
      wr_cnt <= wr_cnt + 1;
    if (cyc > 20000)
    begin
      fail_count = fail_count + 1;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [15:0] seen,
    input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // gap cycle after each write so the strobe is never set twice at once
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    @(posedge clk_sys_i);
    v = reg_rdata_o;
  endtask

  task automatic watch(input int n, output logic hi);
    hi = 1'b0;
    repeat (n)
    begin
      @(posedge clk_sys_i);
      if (tear_sync_line_o === 1'b1)
        hi = 1'b1;
    end
  endtask

  // lane phases as nibbles of state+1; al drops if trigger misses vsync
  task automatic seq(output logic [15:0] s, output logic al);
    logic was;
    tts_lane_t last;
    s = 16'h0;
    al = 1'b1;
    was = 1'b0;
    last = LN_LP11;
    for (int k = 0; k < 3000; k++)
    begin
      @(posedge clk_sys_i);
      if (lane_oe_o === 1'b1)
      begin
        if (!was || lane_state_o !== last)
        begin
          s = {s[11:0], 4'(lane_state_o) + 4'h1};
          if (lane_state_o === LN_TRIG)
            al = (cyc % 300) < 10;
        end
        last = lane_state_o;
        was = 1'b1;
      end
      else if (was)
        break;
    end
  endtask

  // expected result bits: a pass flips its bit, a failure keeps it
  function automatic logic [7:0] nd(input logic [7:0] d, input logic nv,
    input logic ok);
    return {d[7] ^ nv, d[6] ^ ok, d[5:0]};
  endfunction

  initial
  begin
    logic [7:0] d, c, p, xd;
    logic [15:0] s;
    logic hi;
    int n;
    rst_i = 1'b1;
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
    nv_match_i = 1'b1;
    func_ok_i = 1'b1;
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    chk("oe", 16'(lane_oe_o), 16'h0);
    chk("tear", 16'(tear_sync_line_o), 16'h0);
    rd(`TTS_REG_DIAG, d);
    chk("diag", 16'(d), 16'(`TTS_DIAG_RST));
    rd(`TTS_REG_STATE, d);
    chk("asleep", 16'(d[0]), 16'h1);
    rd(4'hf, d);
    chk("unmapped", 16'(d), 16'h0);
    wr(`TTS_REG_ENA, 8'h01);
    rd(`TTS_REG_ENA, d);
    chk("ena", 16'(d), 16'h1);
    // register commands pass through before the first load
    for (int i = 0; i < 4; i++)
    begin
      c = 8'($random(seed)) % 8'hb0;
      if (i == 3)
        c = 8'hda + (c & 8'h03);
      if (c inside {8'h10, 8'h11, 8'h34, 8'h35})
        c = 8'h2a;
      p = 8'($random(seed));
      n = wr_cnt;
      u_host.send({c, p, c ^ p}, 24);
      repeat (8) @(posedge clk_sys_i);
      chk("cfg_wr", 16'(wr_cnt - n), 16'h1);
      chk("cfg", {cfg_cmd_o, cfg_param_o}, {c, p});
    end
    u_host.send(24'h350035, 24);
    watch(400, hi);
    chk("tear_sleep", 16'(hi), 16'h0);
    // first wake from sleep: long timer
    u_host.send(24'h001111, 16);
    repeat (150) @(posedge clk_sys_i);
    rd(`TTS_REG_DIAG, d);
    chk("diag_early", 16'(d), 16'h80);
    repeat (100) @(posedge clk_sys_i);
    rd(`TTS_REG_DIAG, d);
    xd = 8'hc0;
    chk("diag_long", 16'(d), 16'(xd));
    watch(400, hi);
    chk("tear_on", 16'(hi), 16'h1);
    n = wr_cnt;
    u_host.send(24'h360036, 24);
    repeat (8) @(posedge clk_sys_i);
    chk("cfg_after_load", 16'(wr_cnt - n), 16'h0);
    wr(`TTS_REG_CLR, 8'h0f);
    // trigger, refusal and error-report turnarounds
    for (int i = 0; i < 4; i++)
    begin
      if (i == 3)
        u_host.send(24'h350035, 24);
      u_host.send(tp[i], (i == 3) ? 16 : 24);
      @(posedge clk_sys_i);
      fork
        u_host.turn();
        seq(s, hi);
      join
      @(posedge clk_sys_i);
      chk("lane_seq", s, exp_seq[i]);
      chk("trig_vsync", 16'(hi), 16'h1);
      rd(`TTS_REG_STAT, d);
      chk("stat", 16'(d), (i == 0) ? 16'h1 : (i == 2) ? 16'h2 : 16'h0);
      chk("irq", 16'(irq_o), 16'(i == 0));
      wr(`TTS_REG_CLR, 8'h0f);
    end
    // wake while awake with a mismatch: short timer, line forced low
    nv_match_i <= 1'b0;
    u_host.send(24'h001111, 16);
    watch(20, hi);
    rd(`TTS_REG_DIAG, d);
    chk("diag_short_early", 16'(d), 16'(xd));
    rd(`TTS_REG_STATE, d);
    chk("force_low", 16'(d[3]), 16'h1);
    watch(300, hi);
    chk("tear_forced", 16'(hi), 16'h0);
    rd(`TTS_REG_DIAG, d);
    xd = nd(xd, 1'b0, 1'b1);
    chk("diag_mismatch", 16'(d), 16'(xd));
    // functionality failure alone keeps bit 6 and forces the line low;
    // tear-on first, so the force cannot be left over from the mismatch
    u_host.send(24'h350035, 24);
    nv_match_i <= 1'b1;
    func_ok_i <= 1'b0;
    u_host.send(24'h001111, 16);
    repeat (60) @(posedge clk_sys_i);
    rd(`TTS_REG_STATE, d);
    chk("force_func", 16'(d[3]), 16'h1);
    watch(300, hi);
    chk("tear_func_fail", 16'(hi), 16'h0);
    rd(`TTS_REG_DIAG, d);
    xd = nd(xd, 1'b1, 1'b0);
    chk("diag_func_fail", 16'(d), 16'(xd));
    rd(`TTS_REG_STAT, d);
    chk("stat_diag", 16'(d), 16'h0c);
    u_host.send(24'h350035, 24);
    watch(400, hi);
    chk("tear_back", 16'(hi), 16'h1);
    rd(`TTS_REG_STATE, d);
    chk("force_clear", 16'(d[3]), 16'h0);
    conclude();
  end
endmodule
`default_nettype wire
